/* bench/dss_far_ctl.sv */
// Purpose: Far-side control logic driving the select and test reset pins
// Assumes: Bench sets wanted values; pins follow one edge later
// Notes: Test reset is pulsed low after power-up so the port starts clean
`timescale 1ns/100ps
module dss_far_ctl (
    // Clock
    input wire logic i_clk,
    // Wanted settings
    input wire logic [1:0] i_mode,
    input wire logic i_rebuild,
    input wire logic i_range,
    input wire logic i_trst_req,
    // Pins
    output logic o_code_bit0,
    output logic o_code_bit1,
    output logic o_rebuild,
    output logic o_range,
    output logic o_trst_n
);
    logic [3:0] pwr_cnt_reg = 4'h0;
    // Pins come from flops, as real glue logic would
    always_ff @(posedge i_clk) begin
        {o_code_bit1, o_code_bit0} <= i_mode;
        o_rebuild <= i_rebuild;
        o_range <= i_range;
    end
    // power-up test reset
    // Low for eight edges after power-up, or on request
    always_ff @(posedge i_clk) begin
        if (pwr_cnt_reg != 4'h8) begin
            pwr_cnt_reg <= pwr_cnt_reg + 4'h1;
        end
        o_trst_n <= (pwr_cnt_reg == 4'h8) && !i_trst_req;
    end
endmodule

/* bench/dss_top_tb.sv */
// Purpose: Self-checking bench for the status, corrector, register and test port
// Assumes: Hold shortened to 20 cycles; test clock 17 system cycles, 8 high and 9 low
// Notes: Pins pass the far-side model, so waits allow for sync flops
`timescale 1ns/100ps
module dss_top_tb;
    logic i_clk, i_rst_n, i_tck, i_tms, i_tdi, i_wr_en, i_rd_en, hi_tdo;
    logic i_pll_locked, i_pll_holdover, rq_rebuild, rq_range, rq_trst;
    logic [1:0] i_ref_index, rq_mode, o_mode;
    logic [2:0] i_ref_over_ds1, i_ref_over_e1, i_ref_abrupt;
    logic [7:0] i_addr;
    logic [31:0] i_wr_data, o_rd_data, rnd;
    logic i_range_limit_select, i_phase_rebuild_select, i_operating_code_bit0;
    logic i_operating_code_bit1, i_trst_n, o_tdo, o_tdo_oe, o_lock, o_holdover;
    logic o_input_a_fault_flag, o_input_b_fault_flag, o_input_c_fault_flag;
    logic o_corrector_keep, o_corrector_remeasure, o_in_reset, o_outputs_oe, o_irq;
    int failures = 0, n_checks = 0, n_keep = 0, n_rem = 0, cyc = 0, k0, r0;
    localparam int HOLD = 20;

    dss_top #(.HOLD_CYCLES(HOLD)) dut (.i_clk, .i_rst_n, .i_range_limit_select,
        .i_phase_rebuild_select, .i_operating_code_bit0, .i_operating_code_bit1,
        .i_tck, .i_tms, .i_tdi, .i_trst_n, .o_tdo, .o_tdo_oe, .i_pll_locked,
        .i_pll_holdover, .i_ref_index, .i_ref_over_ds1, .i_ref_over_e1, .i_ref_abrupt,
        .o_lock, .o_holdover, .o_input_a_fault_flag, .o_input_b_fault_flag,
        .o_input_c_fault_flag, .o_mode, .o_corrector_keep, .o_corrector_remeasure,
        .o_in_reset, .o_outputs_oe, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en,
        .o_rd_data, .o_irq);
    dss_far_ctl ctl (.i_clk, .i_mode(rq_mode), .i_rebuild(rq_rebuild), .i_range(rq_range),
        .i_trst_req(rq_trst), .o_code_bit0(i_operating_code_bit0),
        .o_code_bit1(i_operating_code_bit1), .o_rebuild(i_phase_rebuild_select),
        .o_range(i_range_limit_select), .o_trst_n(i_trst_n));

    // Clock, 25 ns period
    initial begin
        i_clk = 0;
        forever #12.5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Write strobe set high on every call and left high; caller drops it after the last write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wr_data <= d;
        i_wr_en <= 1;
        @(posedge i_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        i_wr_en <= 0;
        i_addr <= a;
        i_rd_en <= 1;
        @(posedge i_clk);
        i_rd_en <= 0;
        @(negedge i_clk);
        chk(o_rd_data, e);
        @(posedge i_clk);
    endtask

    // One test clock period, high then low, ends mid-cycle for sampling
    task automatic tck_cyc(input logic tms, input logic tdi);
        @(posedge i_clk);
        i_tms <= tms;
        i_tdi <= tdi;
        i_tck <= 1;
        repeat (8) @(posedge i_clk);
        hi_tdo = o_tdo;
        i_tck <= 0;
        repeat (8) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    task automatic wait_look(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    // Pulse counters and hang guard
    always @(posedge i_clk) begin
        cyc++;
        n_keep += o_corrector_keep;
        n_rem += o_corrector_remeasure;
        if (cyc == 3000) begin
            failures++;
            test_done();
        end
    end

    initial begin
        {i_rst_n, i_tck, i_tms, i_tdi, i_wr_en, i_rd_en, i_addr, i_wr_data} = 0;
        {i_pll_locked, i_pll_holdover, rq_rebuild, rq_range, rq_trst, rq_mode} = 0;
        {i_ref_index, i_ref_over_ds1, i_ref_over_e1, i_ref_abrupt} = 0;
        rnd = 32'h000128a3;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1;
        wait_look(10);
        chk({o_in_reset, o_outputs_oe}, 2'b10);
        wait_look(HOLD);
        chk({o_in_reset, o_outputs_oe}, 2'b01);
        // Random core status, every mode code in turn
        for (int i = 0; i < 12; i++) begin
            @(posedge i_clk);
            rnd = lfsr(rnd);
            {i_pll_locked, i_pll_holdover, i_ref_over_ds1, i_ref_over_e1} <= rnd[7:0];
            i_ref_abrupt <= rnd[10:8] & {3{rnd[14]}};
            i_ref_index <= rnd[12] ? 2'd2 : {1'b0, rnd[11]};
            rq_range <= rnd[13];
            rq_mode <= 2'(i);
            wait_look(8);
            chk(o_mode, rq_mode);
            chk(o_lock, i_pll_locked && !i_pll_holdover && rq_mode != 2'b10);
            chk(o_holdover, i_pll_holdover);
            chk({o_input_c_fault_flag, o_input_b_fault_flag, o_input_a_fault_flag},
                (rq_range ? i_ref_over_e1 : i_ref_over_ds1) | i_ref_abrupt);
        end
        @(posedge i_clk);
        {i_pll_locked, i_pll_holdover, i_ref_over_ds1, i_ref_over_e1, i_ref_abrupt} <= 0;
        {i_ref_index, rq_mode} <= 0;
        repeat (8) @(posedge i_clk);
        wr(dss_pkg::OFS_EVENT, 32'h1f);
        wr(dss_pkg::OFS_MASK, 32'h0);
        i_wr_en <= 0;
        i_pll_holdover <= 1;
        repeat (6) @(posedge i_clk);
        rd_chk(dss_pkg::OFS_EVENT, 32'h02);
        chk(o_irq, 0);
        wr(dss_pkg::OFS_MASK, 32'h2);
        rd_chk(dss_pkg::OFS_MASK, 32'h2);
        chk(o_irq, 1);
        k0 = n_keep;
        r0 = n_rem;
        wr(dss_pkg::OFS_EVENT, 32'h2);
        i_wr_en <= 0;
        i_pll_holdover <= 0;
        wait_look(5);
        chk(o_irq, 0);
        chk(n_keep - k0, 1);
        chk(n_rem - r0, 0);
        rd_chk(8'h0c, 32'h0);
        rq_rebuild <= 1;
        i_pll_holdover <= 1;
        repeat (6) @(posedge i_clk);
        i_pll_holdover <= 0;
        wait_look(5);
        chk(n_rem - r0, 1);
        chk(n_keep - k0, 1);
        // Test port: reset state, then walk into instruction shift
        tck_cyc(1, 0);
        chk(o_tdo_oe, 0);
        tck_cyc(0, 0);
        tck_cyc(1, 0);
        tck_cyc(1, 0);
        tck_cyc(0, 0);
        for (int i = 0; i < 4; i++) begin
            tck_cyc(0, 1'(i == 0));
            chk({o_tdo_oe, o_tdo}, {1'b1, dss_pkg::IR_CAPT[i]});
            if (i > 0) begin
                chk(hi_tdo, dss_pkg::IR_CAPT[i - 1]);
            end
        end
        // Test reset in mid-shift with no test clock running
        rq_trst <= 1;
        repeat (6) @(posedge i_clk);
        rq_trst <= 0;
        i_pll_locked <= 1;
        i_ref_abrupt <= 3'h5;
        wait_look(6);
        chk(o_tdo_oe, 0);
        tck_cyc(0, 0);
        chk(o_tdo_oe, 0);
        // Load the sample instruction LSB first, then capture and shift out the flags
        tck_cyc(1, 0);
        tck_cyc(1, 0);
        tck_cyc(0, 0);
        tck_cyc(0, 0);
        for (int i = 0; i < 4; i++) begin
            tck_cyc(1'(i == 3), dss_pkg::IR_SAMPLE[i]);
        end
        tck_cyc(1, 0);
        tck_cyc(1, 0);
        tck_cyc(0, 0);
        // Locked, no holdover, abrupt on a and c: flags read 10101
        for (int i = 0; i < 5; i++) begin
            tck_cyc(0, 0);
            chk({o_tdo_oe, o_tdo}, {1'b1, 1'(5'h15 >> i)});
        end
        test_done();
    end
endmodule

/* core/dss_tap.sv */
// Purpose: Test access port controller with bypass and flag sample registers
// Assumes: TCK edges pre-synchronised into enables on i_clk
// Notes: TCK must stay well below a quarter of the system clock

`timescale 1ns/100ps

module dss_tap (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Link to top
    dss_tap_if.tap bus
);

    dss_pkg::dss_tap_state_t state_reg;
    dss_pkg::dss_tap_state_t state_next;
    logic [3:0] ir_reg;
    logic [3:0] ir_sh_reg;
    logic [4:0] samp_reg;
    logic byp_reg;
    logic tdo_reg;
    logic oe_reg;

    assign bus.state = state_reg;
    assign bus.tdo = tdo_reg;
    assign bus.tdo_oe = oe_reg;

    // Next state from TMS
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dss_pkg::TAP_RESET: state_next = bus.tms ? dss_pkg::TAP_RESET : dss_pkg::TAP_IDLE;
            dss_pkg::TAP_IDLE: state_next = bus.tms ? dss_pkg::TAP_SEL_DR : dss_pkg::TAP_IDLE;
            dss_pkg::TAP_SEL_DR: state_next = bus.tms ? dss_pkg::TAP_SEL_IR : dss_pkg::TAP_CAP_DR;
            dss_pkg::TAP_CAP_DR: state_next = bus.tms ? dss_pkg::TAP_EXIT1_DR : dss_pkg::TAP_SHIFT_DR;
            dss_pkg::TAP_SHIFT_DR: state_next = bus.tms ? dss_pkg::TAP_EXIT1_DR : dss_pkg::TAP_SHIFT_DR;
            dss_pkg::TAP_EXIT1_DR: state_next = bus.tms ? dss_pkg::TAP_UPD_DR : dss_pkg::TAP_PAUSE_DR;
            dss_pkg::TAP_PAUSE_DR: state_next = bus.tms ? dss_pkg::TAP_EXIT2_DR : dss_pkg::TAP_PAUSE_DR;
            dss_pkg::TAP_EXIT2_DR: state_next = bus.tms ? dss_pkg::TAP_UPD_DR : dss_pkg::TAP_SHIFT_DR;
            dss_pkg::TAP_UPD_DR: state_next = bus.tms ? dss_pkg::TAP_SEL_DR : dss_pkg::TAP_IDLE;
            dss_pkg::TAP_SEL_IR: state_next = bus.tms ? dss_pkg::TAP_RESET : dss_pkg::TAP_CAP_IR;
            dss_pkg::TAP_CAP_IR: state_next = bus.tms ? dss_pkg::TAP_EXIT1_IR : dss_pkg::TAP_SHIFT_IR;
            dss_pkg::TAP_SHIFT_IR: state_next = bus.tms ? dss_pkg::TAP_EXIT1_IR : dss_pkg::TAP_SHIFT_IR;
            dss_pkg::TAP_EXIT1_IR: state_next = bus.tms ? dss_pkg::TAP_UPD_IR : dss_pkg::TAP_PAUSE_IR;
            dss_pkg::TAP_PAUSE_IR: state_next = bus.tms ? dss_pkg::TAP_EXIT2_IR : dss_pkg::TAP_PAUSE_IR;
            dss_pkg::TAP_EXIT2_IR: state_next = bus.tms ? dss_pkg::TAP_UPD_IR : dss_pkg::TAP_SHIFT_IR;
            dss_pkg::TAP_UPD_IR: state_next = bus.tms ? dss_pkg::TAP_SEL_DR : dss_pkg::TAP_IDLE;
            default: state_next = dss_pkg::TAP_RESET;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !bus.trst_n) begin
            state_reg <= dss_pkg::TAP_RESET;
        end else if (bus.tck_rise) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !bus.trst_n) begin
            ir_reg <= dss_pkg::IR_BYPASS;
            ir_sh_reg <= dss_pkg::IR_BYPASS;
        end else if (bus.tck_rise) begin
            case (state_reg)
                dss_pkg::TAP_RESET: ir_reg <= dss_pkg::IR_BYPASS;
                dss_pkg::TAP_CAP_IR: ir_sh_reg <= dss_pkg::IR_CAPT;
                dss_pkg::TAP_SHIFT_IR: ir_sh_reg <= {bus.tdi, ir_sh_reg[3:1]};
                dss_pkg::TAP_UPD_IR: ir_reg <= ir_sh_reg;
                default: ir_reg <= ir_reg;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            samp_reg <= 5'h00;
            byp_reg <= 1'b0;
        end else if (bus.tck_rise) begin
            if (state_reg == dss_pkg::TAP_CAP_DR) begin
                samp_reg <= bus.scan_in;
                byp_reg <= 1'b0;
            end else if (state_reg == dss_pkg::TAP_SHIFT_DR) begin
                samp_reg <= {bus.tdi, samp_reg[4:1]};
                byp_reg <= bus.tdi;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tdo_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else if (!bus.trst_n) begin
            // Test reset ends any scan, so the output is released at once
            oe_reg <= 1'b0;
        end else if (bus.tck_fall) begin
            oe_reg <= (state_reg == dss_pkg::TAP_SHIFT_IR) ||
                (state_reg == dss_pkg::TAP_SHIFT_DR);
            if (state_reg == dss_pkg::TAP_SHIFT_IR) begin
                tdo_reg <= ir_sh_reg[0];
            end else if (ir_reg == dss_pkg::IR_SAMPLE) begin
                tdo_reg <= samp_reg[0];
            end else begin
                tdo_reg <= byp_reg;
            end
        end
    end

    chk_trst_forces_reset: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !bus.trst_n |=> state_reg == dss_pkg::TAP_RESET && !oe_reg)
        else $error("test reset did not force reset state");

    chk_tdo_on_fall: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (tdo_reg != $past(tdo_reg)) |-> $past(bus.tck_fall))
        else $error("test output moved off a falling edge");

    chk_tdo_idle_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (bus.tck_fall && state_reg != dss_pkg::TAP_SHIFT_IR &&
        state_reg != dss_pkg::TAP_SHIFT_DR) |=> !oe_reg)
        else $error("test output driven outside shift");

    sequence s_shift_exit;
        state_reg == dss_pkg::TAP_SHIFT_DR && bus.tck_rise && bus.tms && bus.trst_n;
    endsequence

    chk_tms_exit_shift: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_shift_exit |=> state_reg == dss_pkg::TAP_EXIT1_DR)
        else $error("mode select high did not leave shift");

    chk_ir_takes_tdi: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (state_reg == dss_pkg::TAP_SHIFT_IR && bus.tck_rise && bus.trst_n)
        |=> ir_sh_reg[3] == $past(bus.tdi))
        else $error("instruction bit not taken from serial input");

endmodule

/* core/dss_top.sv */
// Purpose: Status flags, mode pins, corrector control and test port of the synchronizer
// Assumes: Pins are asynchronous; PLL core status inputs share i_clk
// Notes: Internal reset hold is a parameter so simulation can shorten it
//
// The implementer's own choices: the register addresses and the address-and-strobe port.

`timescale 1ns/100ps

module dss_top #(
    parameter int HOLD_CYCLES = dss_pkg::HOLD_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control pins
    input wire logic i_range_limit_select,
    input wire logic i_phase_rebuild_select,
    input wire logic i_operating_code_bit0,
    input wire logic i_operating_code_bit1,
    // Test port pins
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic i_trst_n,
    output logic o_tdo,
    output logic o_tdo_oe,
    // PLL core status
    input wire logic i_pll_locked,
    input wire logic i_pll_holdover,
    input wire logic [1:0] i_ref_index,
    input wire logic [2:0] i_ref_over_ds1,
    input wire logic [2:0] i_ref_over_e1,
    input wire logic [2:0] i_ref_abrupt,
    // Status pins
    output logic o_lock,
    output logic o_holdover,
    output logic o_input_a_fault_flag,
    output logic o_input_b_fault_flag,
    output logic o_input_c_fault_flag,
    // Core control
    output logic [1:0] o_mode,
    output logic o_corrector_keep,
    output logic o_corrector_remeasure,
    output logic o_in_reset,
    output logic o_outputs_oe,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [31:0] o_rd_data,
    output logic o_irq
);

    localparam int NPIN = 8;
    localparam logic [16:0] HOLD_LAST = 17'(HOLD_CYCLES - 1);

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_m_reg;
    logic [NPIN-1:0] pin_s_reg;
    logic tck_d_reg;
    logic [16:0] hold_cnt_reg;
    logic run_reg;
    logic in_rst_reg;
    logic lock_reg;
    logic hold_reg;
    logic [2:0] fault_reg;
    logic [2:0] fault_cond;
    dss_pkg::dss_mode_t mode_reg;
    logic off_reg;
    logic [1:0] left_ref_reg;
    logic off_now;
    logic keep_reg;
    logic remeas_reg;
    logic [4:0] live;
    logic [4:0] event_reg;
    logic [4:0] event_next;
    logic [4:0] event_set;
    logic [4:0] mask_reg;
    logic [31:0] rd_reg;
    logic irq_reg;
    logic [4:0] live_d_reg;

    dss_tap_if tap_bus ();

    assign pin_raw = {i_trst_n, i_tdi, i_tms, i_tck, i_operating_code_bit1,
        i_operating_code_bit0, i_phase_rebuild_select, i_range_limit_select};

    // Two-flop synchronisers, one per pin
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    pin_m_reg[gi] <= 1'b0;
                    pin_s_reg[gi] <= 1'b0;
                end else begin
                    pin_m_reg[gi] <= pin_raw[gi];
                    pin_s_reg[gi] <= pin_m_reg[gi];
                end
            end
        end
    endgenerate

    // Test clock edge detect on the synchronised copy
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tck_d_reg <= 1'b0;
        end else begin
            tck_d_reg <= pin_s_reg[4];
        end
    end

    assign tap_bus.tck_rise = pin_s_reg[4] && !tck_d_reg;
    assign tap_bus.tck_fall = !pin_s_reg[4] && tck_d_reg;
    assign tap_bus.tms = pin_s_reg[5];
    assign tap_bus.tdi = pin_s_reg[6];
    assign tap_bus.trst_n = pin_s_reg[7];
    assign tap_bus.scan_in = {fault_reg, hold_reg, lock_reg};

    dss_tap u_tap (
        .i_clk (i_clk),
        .i_rst_n (i_rst_n),
        .bus (tap_bus)
    );

    assign o_tdo = tap_bus.tdo;
    assign o_tdo_oe = tap_bus.tdo_oe;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            hold_cnt_reg <= 17'h00000;
            run_reg <= 1'b0;
            in_rst_reg <= 1'b1;
        end else if (!run_reg) begin
            if (hold_cnt_reg == HOLD_LAST) begin
                run_reg <= 1'b1;
                // Own flop so the pin never sees an inverter glitch
                in_rst_reg <= 1'b0;
            end else begin
                hold_cnt_reg <= hold_cnt_reg + 17'h00001;
            end
        end
    end

    assign o_in_reset = in_rst_reg;
    assign o_outputs_oe = run_reg;

    // mode decode, held at normal while in reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !run_reg) begin
            mode_reg <= dss_pkg::MODE_NORMAL;
        end else begin
            mode_reg <= dss_pkg::dss_mode_t'({pin_s_reg[3], pin_s_reg[2]});
        end
    end

    assign o_mode = mode_reg;
    assign off_now = i_pll_holdover || (mode_reg == dss_pkg::MODE_FREERUN);

    // limit chosen by range select; abrupt change always counts
    assign fault_cond = (pin_s_reg[0] ? i_ref_over_e1 : i_ref_over_ds1) | i_ref_abrupt;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !run_reg) begin
            lock_reg <= 1'b0;
            hold_reg <= 1'b0;
            fault_reg <= 3'h0;
        end else begin
            lock_reg <= i_pll_locked && !off_now;
            hold_reg <= i_pll_holdover;
            fault_reg <= fault_cond;
        end
    end

    assign o_lock = lock_reg;
    assign o_holdover = hold_reg;
    assign o_input_a_fault_flag = fault_reg[0];
    assign o_input_b_fault_flag = fault_reg[1];
    assign o_input_c_fault_flag = fault_reg[2];

    // fresh delay when rebuild select is high
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !run_reg) begin
            off_reg <= 1'b0;
            left_ref_reg <= 2'h0;
            keep_reg <= 1'b0;
            remeas_reg <= 1'b0;
        end else begin
            off_reg <= off_now;
            keep_reg <= 1'b0;
            remeas_reg <= 1'b0;
            if (off_now && !off_reg) begin
                left_ref_reg <= i_ref_index;
            end
            if (off_reg && !off_now) begin
                // A different input cannot reuse the old delay
                if (!pin_s_reg[1] && i_ref_index == left_ref_reg) begin
                    keep_reg <= 1'b1;
                end else begin
                    remeas_reg <= 1'b1;
                end
            end
        end
    end

    assign o_corrector_keep = keep_reg;
    assign o_corrector_remeasure = remeas_reg;

    // Events: lock lost, holdover entered, each fault raised
    assign live = {fault_reg, hold_reg, lock_reg};
    assign event_set = {fault_reg & ~live_d_reg[4:2], hold_reg & ~live_d_reg[1],
        live_d_reg[0] & ~lock_reg};

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            live_d_reg <= 5'h00;
        end else begin
            live_d_reg <= live;
        end
    end

    // Write one to clear; a new event in the same cycle survives
    always_comb begin
        event_next = event_reg;
        if (i_wr_en && i_addr == dss_pkg::OFS_EVENT) begin
            event_next = event_reg & ~i_wr_data[4:0];
        end
        event_next = event_next | event_set;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            event_reg <= dss_pkg::EVENT_RST;
            mask_reg <= dss_pkg::MASK_RST;
        end else begin
            event_reg <= event_next;
            if (i_wr_en && i_addr == dss_pkg::OFS_MASK) begin
                mask_reg <= i_wr_data[4:0];
            end
        end
    end

    // Level interrupt from unmasked sticky bits
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(event_next & mask_reg);
        end
    end

    assign o_irq = irq_reg;

    // Read data stands one cycle only; unmapped reads give zero
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !i_rd_en) begin
            rd_reg <= 32'h00000000;
        end else if (i_addr == dss_pkg::OFS_LIVE) begin
            rd_reg <= {27'h0000000, live};
        end else if (i_addr == dss_pkg::OFS_EVENT) begin
            rd_reg <= {27'h0000000, event_reg};
        end else if (i_addr == dss_pkg::OFS_MASK) begin
            rd_reg <= {27'h0000000, mask_reg};
        end else begin
            rd_reg <= 32'h00000000;
        end
    end

    assign o_rd_data = rd_reg;

    chk_lock_needs_pll: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_lock |-> $past(i_pll_locked) && !$past(i_pll_holdover))
        else $error("lock flag high without loop lock");

    chk_holdover_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (run_reg && i_pll_holdover) |=> o_holdover)
        else $error("holdover flag missed holdover");

    chk_fault_a_sel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (run_reg && pin_s_reg[0] && i_ref_over_e1[0]) |=> o_input_a_fault_flag)
        else $error("fault flag missed range excess");

    chk_fault_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !fault_cond[1] |=> !o_input_b_fault_flag)
        else $error("fault flag stayed after requalify");

    chk_hold_after_rst: assert property (@(posedge i_clk)
        $rose(i_rst_n) |-> !o_outputs_oe [*8])
        else $error("outputs enabled too soon after reset");

    chk_hold_length: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_outputs_oe) |-> $past(hold_cnt_reg) == HOLD_LAST)
        else $error("reset hold length wrong");

    chk_mode_decode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (run_reg && $past(run_reg)) |-> o_mode == $past({pin_s_reg[3], pin_s_reg[2]}))
        else $error("mode not decoded from code pins");

    sequence s_return_normal;
        run_reg && off_reg && !off_now;
    endsequence

    chk_keep_same_ref: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (s_return_normal and (!pin_s_reg[1] && i_ref_index == left_ref_reg))
        |=> o_corrector_keep && !o_corrector_remeasure)
        else $error("stored delay not kept");

    chk_remeasure_hms: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (s_return_normal and pin_s_reg[1]) |=> o_corrector_remeasure ##1 !o_corrector_remeasure)
        else $error("fresh delay not requested");

endmodule

/* pkg/dss_pkg.sv */
// Purpose: Shared constants and types for the synchronizer status and control block
// Assumes: 40 MHz system clock, register port with 32-bit data
// Notes: Mode code assignment and register offsets are local decisions

package dss_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_LIVE = 8'h00;
    localparam logic [7:0] OFS_EVENT = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;

    // Live and event field positions
    localparam int BIT_LOCK = 0;
    localparam int BIT_HOLD = 1;
    localparam int BIT_FAULT = 2;
    localparam int NUM_REF = 3;
    localparam int FLAG_W = 5;

    // Reset values
    localparam logic [4:0] EVENT_RST = 5'h00;
    localparam logic [4:0] MASK_RST = 5'h00;

    // Timing: internal reset hold after release
    localparam int CLK_HZ = 40_000_000;
    localparam int HOLD_MS = 3;
    localparam int HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
    localparam int HOLD_CNT_W = 17;

    // Operating mode codes
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_HOLDOVER = 2'b01,
        MODE_FREERUN = 2'b10,
        MODE_AUTO = 2'b11
    } dss_mode_t;

    // Test access port states
    typedef enum logic [3:0] {
        TAP_RESET = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3,
        TAP_SHIFT_DR = 4'h4,
        TAP_EXIT1_DR = 4'h5,
        TAP_PAUSE_DR = 4'h6,
        TAP_EXIT2_DR = 4'h7,
        TAP_UPD_DR = 4'h8,
        TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'ha,
        TAP_SHIFT_IR = 4'hb,
        TAP_EXIT1_IR = 4'hc,
        TAP_PAUSE_IR = 4'hd,
        TAP_EXIT2_IR = 4'he,
        TAP_UPD_IR = 4'hf
    } dss_tap_state_t;

    // Instructions
    localparam int IR_W = 4;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    localparam logic [3:0] IR_SAMPLE = 4'h1;
    localparam logic [3:0] IR_CAPT = 4'h1;

endpackage

/* pkg/dss_tap_if.sv */
// Purpose: Carrier between the top block and its test access port
// Assumes: All signals on the system clock
// Notes: TCK edges arrive as one-cycle enables

`timescale 1ns/100ps

interface dss_tap_if;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic trst_n;
    logic [4:0] scan_in;
    logic tdo;
    logic tdo_oe;
    dss_pkg::dss_tap_state_t state;

    modport tap (
        input tck_rise, tck_fall, tms, tdi, trst_n, scan_in,
        output tdo, tdo_oe, state
    );
    modport core (
        output tck_rise, tck_fall, tms, tdi, trst_n, scan_in,
        input tdo, tdo_oe, state
    );
endinterface
